// *** inc/rfcw_pkg.sv ***
// Constants for the frame CRC, transmit framing and transmit wait block.
// Assumes a single 20 MHz system clock and byte-wide register access.
// Behaviour
// - Forward bit set copies received CRC bytes to FIFO; clear only checks them.
// - Receive preset code picks the fixed CRC16, CRC8 or CRC5 start value.
// - Preset code 6h takes the start value from the nonvolatile configuration.
// - Two-bit type picks CRC5, CRC8 or CRC16; code 3h is reserved.
// - Inversion bit checks the frame against the inverted CRC.
// - Check enabled flags a mismatch; disabled computes but leaves the flag.
// - Bit-grid hold spaces transmission starts by whole ETUs.
// - Payload enable clear sends one symbol pattern; set sends the data bytes.
// - Last-bits field sends that many final-byte bits LSB first; 0 means 8.
// - Burst code 0 to 7 selects 8, 16, 32, 48, 64, 96, 128, 256 bits.
// - Wait starts at end of transmit when reference clear, receive when set.
// - Wait count lasts 16 carrier cycles, or half a bit period when set.
// - Wait control bits 5 to 3 are the upper wait bits, bit 5 the MSB.
// - Wait value is 11 bits, the low byte plus the three upper bits.
// - Stop field selects no stop, one stop, or stop plus 1 to 6 guard units.
// - Wait control resets to C0h.
package rfcw_pkg;

	localparam logic [7:0] OFS_RX_CRC = 8'h2D;
	localparam logic [7:0] OFS_TX_DATA = 8'h2E;
	localparam logic [7:0] OFS_TX_BURST = 8'h30;
	localparam logic [7:0] OFS_TX_WAIT = 8'h31;

	localparam logic [7:0] RST_RX_CRC = 8'h00;
	localparam logic [7:0] RST_TX_DATA = 8'h00;
	localparam logic [7:0] RST_TX_BURST = 8'h00;
	localparam logic [7:0] RST_TX_WAIT = 8'hC0;
	localparam logic [7:0] MASK_TX_DATA = 8'h1F;
	localparam logic [7:0] MASK_TX_BURST = 8'h70;

	localparam int RXC_FWD = 7;
	localparam int RXC_PRE = 4;
	localparam int RXC_TYPE = 2;
	localparam int RXC_INV = 1;
	localparam int RXC_EN = 0;
	localparam int TXD_GRID = 4;
	localparam int TXD_DATA = 3;
	localparam int TXD_LAST = 0;
	localparam int TXB_LEN = 4;
	localparam int TXW_START = 7;
	localparam int TXW_BASE = 6;
	localparam int TXW_HIGH = 3;
	localparam int TXW_STOP = 0;

	localparam logic [1:0] CRC_T5 = 2'h0;
	localparam logic [1:0] CRC_T8 = 2'h1;
	localparam logic [1:0] CRC_T16 = 2'h2;
	localparam logic [15:0] POLY16 = 16'h8408;
	localparam logic [15:0] POLY8 = 16'h00B8;
	localparam logic [15:0] POLY5 = 16'h0012;
	localparam logic [15:0] MASK16 = 16'hFFFF;
	localparam logic [15:0] MASK8 = 16'h00FF;
	localparam logic [15:0] MASK5 = 16'h001F;
	localparam logic [2:0] PRESET_USER = 3'h6;
	localparam logic [7:0][15:0] PRE16 = {16'hFFFF, 16'h0000, 16'h0000,
		16'h0000, 16'hFFFE, 16'hA671, 16'h6363, 16'h0000};
	localparam logic [7:0][15:0] PRE8 = {16'h00FF, 16'h0000, 16'h0000,
		16'h0000, 16'h00FD, 16'h00BF, 16'h0012, 16'h0000};
	localparam logic [7:0][15:0] PRE5 = {16'h001F, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0012, 16'h0000};

	localparam logic [7:0][8:0] BURST_BITS = {9'h100, 9'h080, 9'h060,
		9'h040, 9'h030, 9'h020, 9'h010, 9'h008};

	localparam int WAIT_W = 11;
	localparam int CLK_KHZ = 20000;
	localparam int CARRIER_KHZ = 13560;
	localparam int WAIT_CARRIER_CYCLES = 16;
	localparam int WAIT_UNIT_CYCLES =
		(WAIT_CARRIER_CYCLES * CLK_KHZ + CARRIER_KHZ - 1) / CARRIER_KHZ;

	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 32;

endpackage

// *** inc/rfcw_stream_if.sv ***
// Valid/ready byte stream between the framer and its receive FIFO.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface rfcw_stream_if #(parameter int WIDTH = 8);
	logic [WIDTH-1:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

// *** design/rfcw_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
// Assumes WIDTH matches the connected stream interfaces.
`timescale 1ns/100ps
module rfcw_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and control
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Streams
	rfcw_stream_if.snk push,
	rfcw_stream_if.src pop
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [CW-1:0] cnt_q;
	logic do_push;
	logic do_pop;

	assign push.ready = (cnt_q != FULL);
	assign pop.valid = (cnt_q != '0);
	assign pop.data = mem[rd_q];
	assign do_push = ce_i && push.valid && push.ready;
	assign do_pop = ce_i && pop.valid && pop.ready;

	always_ff @(posedge clk_i)
	begin
		if (do_push)
		begin
			mem[wr_q] <= push.data;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (do_push)
			begin
				wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
			end
			if (do_pop)
			begin
				rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
			end
			if (do_push && !do_pop)
			begin
				cnt_q <= cnt_q + 1'b1;
			end
			else if (do_pop && !do_push)
			begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

endmodule

// *** design/rfcw_crc.sv ***
// Bytewise reflected CRC engine for CRC5, CRC8 and CRC16, LSB first.
// Assumes the caller presents the start value with init on a frame's first byte.
`timescale 1ns/100ps
module rfcw_crc (
	// Clock and control
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Configuration
	input wire logic [1:0] type_i,
	input wire logic [15:0] start_i,
	// Data
	input wire logic init_i,
	input wire logic valid_i,
	input wire logic [7:0] data_i,
	output logic [15:0] crc_o
);
	logic [15:0] crc_q;
	logic [15:0] poly;
	logic [15:0] crc_d;

	always_comb
	begin
		unique case (type_i)
			rfcw_pkg::CRC_T5: poly = rfcw_pkg::POLY5;
			rfcw_pkg::CRC_T8: poly = rfcw_pkg::POLY8;
			default: poly = rfcw_pkg::POLY16;
		endcase
	end

	// Shifting right keeps the short polynomials inside their own width.
	always_comb
	begin
		crc_d = init_i ? start_i : crc_q;
		if (valid_i)
		begin
			for (int i = 0; i < 8; i++)
			begin
				if (crc_d[0] ^ data_i[i])
				begin
					crc_d = (crc_d >> 1) ^ poly;
				end
				else
				begin
					crc_d = crc_d >> 1;
				end
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			crc_q <= '0;
		end
		else if (ce_i && (init_i || valid_i))
		begin
			crc_q <= crc_d;
		end
	end

	assign crc_o = crc_q;

endmodule

// *** design/rfcw_top.sv ***
// Frame configuration: receive CRC check and forwarding, transmit framing
// fields and the minimum wait before a transmission.
// Assumes receive bytes, frame end pulses and the transmit request all come
// from logic on the same clock; the wait low byte and bit rate are inputs.
`timescale 1ns/100ps
module rfcw_top (
	// Clock, reset and enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Nonvolatile start value and external wait/rate settings
	input wire logic [15:0] user_crc_preset_i,
	input wire logic [7:0] wait_lower_byte_i,
	input wire logic [11:0] half_bit_cycles_i,
	// Receive byte stream
	input wire logic [7:0] rx_data_i,
	input wire logic rx_valid_i,
	input wire logic rx_last_i,
	output logic rx_ready_o,
	// Receive status
	input wire logic rx_crc_err_clear_i,
	output logic rx_crc_error_o,
	output logic rx_check_done_o,
	// FIFO drain
	output logic [7:0] fifo_data_o,
	output logic fifo_valid_o,
	input wire logic fifo_ready_i,
	// Transmit timing
	input wire logic tx_req_i,
	output logic tx_go_o,
	input wire logic tx_end_i,
	input wire logic rx_end_i,
	output logic wait_active_o,
	// Transmit framing settings
	output logic tx_payload_enable_o,
	output logic [3:0] tx_final_byte_bits_o,
	output logic [8:0] symbol_one_burst_size_o,
	output logic tx_stop_bit_o,
	output logic [2:0] tx_guard_units_o
);
	typedef enum logic [1:0] {RX_PASS, RX_FLUSH, RX_CHECK} rfcw_rx_state_t;

	logic [7:0] rx_crc_control_q;
	logic [7:0] tx_data_count_q;
	logic [7:0] tx_burst_length_q;
	logic [7:0] tx_wait_control_q;
	logic [7:0] rdata_q;

	rfcw_stream_if #(.WIDTH(rfcw_pkg::FIFO_WIDTH)) push_if ();
	rfcw_stream_if #(.WIDTH(rfcw_pkg::FIFO_WIDTH)) pop_if ();

	////////////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rx_crc_control_q <= rfcw_pkg::RST_RX_CRC;
			tx_data_count_q <= rfcw_pkg::RST_TX_DATA;
			tx_burst_length_q <= rfcw_pkg::RST_TX_BURST;
			tx_wait_control_q <= rfcw_pkg::RST_TX_WAIT;
		end
		else if (ce_i && reg_wr_i)
		begin
			unique case (reg_addr_i)
				rfcw_pkg::OFS_RX_CRC: rx_crc_control_q <= reg_wdata_i;
				rfcw_pkg::OFS_TX_DATA:
					tx_data_count_q <= reg_wdata_i & rfcw_pkg::MASK_TX_DATA;
				rfcw_pkg::OFS_TX_BURST:
					tx_burst_length_q <= reg_wdata_i & rfcw_pkg::MASK_TX_BURST;
				rfcw_pkg::OFS_TX_WAIT: tx_wait_control_q <= reg_wdata_i;
				default: ;
			endcase
		end
	end

	// Unmapped offsets read as zero so other blocks can share the port.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rdata_q <= '0;
		end
		else if (ce_i && reg_rd_i)
		begin
			unique case (reg_addr_i)
				rfcw_pkg::OFS_RX_CRC: rdata_q <= rx_crc_control_q;
				rfcw_pkg::OFS_TX_DATA: rdata_q <= tx_data_count_q;
				rfcw_pkg::OFS_TX_BURST: rdata_q <= tx_burst_length_q;
				rfcw_pkg::OFS_TX_WAIT: rdata_q <= tx_wait_control_q;
				default: rdata_q <= '0;
			endcase
		end
	end

	assign reg_rdata_o = rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// Receive CRC configuration.

	logic crc_fwd;
	logic [2:0] crc_pre;
	logic [1:0] crc_type;
	logic [15:0] crc_start;
	logic [15:0] crc_mask;
	logic [1:0] crc_len;

	assign crc_fwd = rx_crc_control_q[rfcw_pkg::RXC_FWD];
	assign crc_pre = rx_crc_control_q[rfcw_pkg::RXC_PRE +: 3];
	assign crc_type = rx_crc_control_q[rfcw_pkg::RXC_TYPE +: 2];

	always_comb
	begin
		unique case (crc_type)
			rfcw_pkg::CRC_T5:
			begin
				crc_start = rfcw_pkg::PRE5[crc_pre];
				crc_mask = rfcw_pkg::MASK5;
				crc_len = 2'h1;
			end
			rfcw_pkg::CRC_T8:
			begin
				crc_start = rfcw_pkg::PRE8[crc_pre];
				crc_mask = rfcw_pkg::MASK8;
				crc_len = 2'h1;
			end
			rfcw_pkg::CRC_T16:
			begin
				crc_start = rfcw_pkg::PRE16[crc_pre];
				crc_mask = rfcw_pkg::MASK16;
				crc_len = 2'h2;
			end
			default:
			begin
				crc_start = '0;
				crc_mask = '0;
				crc_len = 2'h0;
			end
		endcase
		if (crc_pre == rfcw_pkg::PRESET_USER)
		begin
			crc_start = user_crc_preset_i & crc_mask;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive path: trailing CRC bytes are held back until the frame ends.

	rfcw_rx_state_t rx_state_q;
	logic [1:0][7:0] hold_q;
	logic [1:0] hold_cnt_q;
	logic [1:0] flush_idx_q;
	logic frame_open_q;
	logic err_q;
	logic done_q;
	logic accept;
	logic exit_byte;
	logic [7:0] exit_data;
	logic [15:0] crc_val;
	logic [15:0] crc_rx;
	logic [15:0] crc_expect;

	assign rx_ready_o = (rx_state_q == RX_PASS) && push_if.ready;
	assign accept = ce_i && rx_valid_i && rx_ready_o;
	assign exit_byte = accept && (hold_cnt_q == crc_len);
	assign exit_data = (crc_len == 2'h2) ? hold_q[1] :
		(crc_len == 2'h1) ? hold_q[0] : rx_data_i;

	always_comb
	begin
		push_if.valid = 1'b0;
		push_if.data = exit_data;
		if (rx_state_q == RX_PASS)
		begin
			push_if.valid = exit_byte && ce_i;
		end
		else if (rx_state_q == RX_FLUSH)
		begin
			push_if.valid = ce_i;
			push_if.data = hold_q[flush_idx_q - 2'h1];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rx_state_q <= RX_PASS;
			hold_q <= '0;
			hold_cnt_q <= '0;
			flush_idx_q <= '0;
			frame_open_q <= 1'b0;
		end
		else if (ce_i)
		begin
			unique case (rx_state_q)
				RX_PASS:
				begin
					if (accept)
					begin
						hold_q <= {hold_q[0], rx_data_i};
						frame_open_q <= !rx_last_i;
						if (!exit_byte)
						begin
							hold_cnt_q <= hold_cnt_q + 2'h1;
						end
						if (rx_last_i && crc_fwd && crc_len != 2'h0)
						begin
							rx_state_q <= RX_FLUSH;
							flush_idx_q <= crc_len;
						end
						else if (rx_last_i)
						begin
							rx_state_q <= RX_CHECK;
						end
					end
				end
				RX_FLUSH:
				begin
					if (push_if.ready)
					begin
						flush_idx_q <= flush_idx_q - 2'h1;
						if (flush_idx_q == 2'h1)
						begin
							rx_state_q <= RX_CHECK;
						end
					end
				end
				RX_CHECK:
				begin
					rx_state_q <= RX_PASS;
					hold_cnt_q <= '0;
				end
			endcase
		end
	end

	rfcw_crc u_crc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.type_i(crc_type),
		.start_i(crc_start),
		.init_i(accept && !frame_open_q),
		.valid_i(exit_byte && crc_len != 2'h0),
		.data_i(exit_data),
		.crc_o(crc_val)
	);

	// Received CRC arrives low byte first.
	assign crc_rx = (crc_len == 2'h2) ? {hold_q[0], hold_q[1]} :
		({8'h00, hold_q[0]} & crc_mask);
	assign crc_expect = rx_crc_control_q[rfcw_pkg::RXC_INV] ?
		(~crc_val & crc_mask) : crc_val;

	// A mismatch in the clearing cycle still sets the flag.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			err_q <= 1'b0;
			done_q <= 1'b0;
		end
		else if (ce_i)
		begin
			done_q <= (rx_state_q == RX_CHECK);
			err_q <= (err_q && !rx_crc_err_clear_i) ||
				(rx_state_q == RX_CHECK && crc_len != 2'h0 &&
				rx_crc_control_q[rfcw_pkg::RXC_EN] &&
				crc_rx != crc_expect);
		end
	end

	assign rx_crc_error_o = err_q;
	assign rx_check_done_o = done_q;

	rfcw_fifo #(
		.WIDTH(rfcw_pkg::FIFO_WIDTH),
		.DEPTH(rfcw_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.push(push_if.snk),
		.pop(pop_if.src)
	);

	assign fifo_data_o = pop_if.data;
	assign fifo_valid_o = pop_if.valid;
	assign pop_if.ready = fifo_ready_i;

	////////////////////////////////////////////////////////////////////////////
	// Transmit wait and bit grid.

	localparam logic [11:0] UNIT_CYC = 12'(rfcw_pkg::WAIT_UNIT_CYCLES);

	logic [rfcw_pkg::WAIT_W-1:0] wait_val;
	logic [rfcw_pkg::WAIT_W-1:0] wait_cnt_q;
	logic [11:0] pre_q;
	logic [11:0] unit;
	logic ref_evt;
	logic wait_done;
	logic [12:0] grid_q;
	logic [12:0] etu_last;
	logic grid_seen_q;
	logic grid_ok;

	assign wait_val = {tx_wait_control_q[rfcw_pkg::TXW_HIGH +: 3],
		wait_lower_byte_i};
	assign ref_evt = tx_wait_control_q[rfcw_pkg::TXW_START] ?
		rx_end_i : tx_end_i;
	assign unit = tx_wait_control_q[rfcw_pkg::TXW_BASE] ?
		half_bit_cycles_i : UNIT_CYC;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wait_cnt_q <= '0;
			pre_q <= '0;
		end
		else if (ce_i)
		begin
			if (ref_evt)
			begin
				wait_cnt_q <= wait_val;
				pre_q <= '0;
			end
			else if (wait_cnt_q != '0)
			begin
				if (pre_q >= unit - 12'h001)
				begin
					pre_q <= '0;
					wait_cnt_q <= wait_cnt_q - 1'b1;
				end
				else
				begin
					pre_q <= pre_q + 12'h001;
				end
			end
		end
	end

	assign etu_last = {half_bit_cycles_i, 1'b0} - 13'h0001;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			grid_q <= '0;
			grid_seen_q <= 1'b0;
		end
		else if (ce_i)
		begin
			if (tx_go_o)
			begin
				// Counting from one makes zero mean a whole ETU has passed.
				grid_q <= 13'h0001;
				grid_seen_q <= 1'b1;
			end
			else
			begin
				grid_q <= (grid_q >= etu_last) ? '0 : grid_q + 13'h0001;
			end
		end
	end

	assign grid_ok = !tx_data_count_q[rfcw_pkg::TXD_GRID] || !grid_seen_q ||
		(grid_q == '0);
	assign wait_done = (wait_cnt_q == '0) && !ref_evt;
	assign wait_active_o = !wait_done;
	assign tx_go_o = ce_i && tx_req_i && wait_done && grid_ok;

	////////////////////////////////////////////////////////////////////////////
	// Transmit framing settings, registered for the modulator.

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tx_payload_enable_o <= 1'b0;
			tx_final_byte_bits_o <= 4'h8;
			symbol_one_burst_size_o <= rfcw_pkg::BURST_BITS[0];
			tx_stop_bit_o <= 1'b0;
			tx_guard_units_o <= '0;
		end
		else if (ce_i)
		begin
			tx_payload_enable_o <= tx_data_count_q[rfcw_pkg::TXD_DATA];
			tx_final_byte_bits_o <=
				(tx_data_count_q[rfcw_pkg::TXD_LAST +: 3] == 3'h0) ? 4'h8 :
				{1'b0, tx_data_count_q[rfcw_pkg::TXD_LAST +: 3]};
			symbol_one_burst_size_o <= rfcw_pkg::BURST_BITS[
				tx_burst_length_q[rfcw_pkg::TXB_LEN +: 3]];
			tx_stop_bit_o <=
				(tx_wait_control_q[rfcw_pkg::TXW_STOP +: 3] != 3'h0);
			tx_guard_units_o <=
				(tx_wait_control_q[rfcw_pkg::TXW_STOP +: 3] > 3'h1) ?
				tx_wait_control_q[rfcw_pkg::TXW_STOP +: 3] - 3'h1 : 3'h0;
		end
	end

endmodule

// *** verif/rfcw_top_chk.sv ***
// Port checker for the frame configuration block.
// Assumes it is bound to rfcw_top and sees only that module's ports.
`timescale 1ns/100ps
module rfcw_top_chk (
	// Clock and control
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Register port and wait setting
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [7:0] wait_lower_byte_i,
	// Status and transmit timing
	input wire logic rx_crc_err_clear_i,
	input wire logic rx_crc_error_o,
	input wire logic rx_check_done_o,
	input wire logic tx_req_i,
	input wire logic tx_go_o,
	input wire logic tx_end_i,
	input wire logic rx_end_i,
	input wire logic wait_active_o,
	// Framing decodes
	input wire logic tx_payload_enable_o,
	input wire logic [3:0] tx_final_byte_bits_o,
	input wire logic [8:0] symbol_one_burst_size_o,
	input wire logic tx_stop_bit_o,
	input wire logic [2:0] tx_guard_units_o
);
	logic [7:0] num_q;
	logic [7:0] bst_q;
	logic [7:0] wt_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////////////
	// Shadow copies let the decodes be judged without seeing inside.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			num_q <= 8'h00;
			bst_q <= 8'h00;
			wt_q <= 8'hC0;
		end
		else if (ce_i && reg_wr_i)
		begin
			if (reg_addr_i == rfcw_pkg::OFS_TX_DATA)
				num_q <= reg_wdata_i;
			if (reg_addr_i == rfcw_pkg::OFS_TX_BURST)
				bst_q <= reg_wdata_i;
			if (reg_addr_i == rfcw_pkg::OFS_TX_WAIT)
				wt_q <= reg_wdata_i;
		end
	end
	function automatic logic [8:0] burst_of(input logic [7:0] b);
		case (b[6:4])
			3'h0: burst_of = 9'h008;
			3'h5: burst_of = 9'h060;
			3'h6: burst_of = 9'h080;
			3'h7: burst_of = 9'h100;
			default: burst_of = {2'h0, b[6:4], 4'h0};
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////
	property p_go_cause;
		tx_go_o |-> ce_i && tx_req_i && !wait_active_o;
	endproperty
	a_go_cause: assert property (p_go_cause)
		else $error("Grant without request or during wait.");
	property p_ref_edge;
		ce_i && (wt_q[7] ? rx_end_i : tx_end_i) |-> wait_active_o;
	endproperty
	a_ref_edge: assert property (p_ref_edge)
		else $error("Reference pulse did not start the wait.");
	property p_wait_len;
		ce_i && rx_end_i && wt_q[7:3] == 5'h10 && wait_lower_byte_i == 8'h01
			|-> wait_active_o [*8] ##18 !wait_active_o;
	endproperty
	a_wait_len: assert property (p_wait_len)
		else $error("One carrier-based wait count has the wrong length.");
	property p_rd_wait;
		ce_i && reg_rd_i && !reg_wr_i && reg_addr_i == rfcw_pkg::OFS_TX_WAIT
			|=> reg_rdata_o == $past(wt_q);
	endproperty
	a_rd_wait: assert property (p_rd_wait)
		else $error("Wait control read back wrong.");
	property p_burst;
		1'b1 |-> symbol_one_burst_size_o == burst_of($past(bst_q));
	endproperty
	a_burst: assert property (p_burst)
		else $error("Burst length decode wrong.");
	property p_tail;
		{tx_stop_bit_o, tx_guard_units_o} == {$past(wt_q[2:0]) != 3'h0,
			$past(wt_q[2:1]) != 2'h0 ? $past(wt_q[2:0]) - 3'h1 : 3'h0};
	endproperty
	a_tail: assert property (p_tail)
		else $error("Frame tail decode wrong.");
	property p_last;
		{tx_payload_enable_o, tx_final_byte_bits_o} == {$past(num_q[3]),
			$past(num_q[2:0]) == 3'h0 ? 4'h8 : {1'b0, $past(num_q[2:0])}};
	endproperty
	a_last: assert property (p_last)
		else $error("Payload or final byte decode wrong.");
	property p_err_hold;
		rx_crc_error_o && !rx_crc_err_clear_i |=> rx_crc_error_o;
	endproperty
	a_err_hold: assert property (p_err_hold)
		else $error("Error flag dropped without a clear.");
	c_go: cover property (tx_go_o);
	c_err: cover property (rx_check_done_o && rx_crc_error_o);
	c_ok: cover property (rx_check_done_o && !rx_crc_error_o);
endmodule
bind rfcw_top rfcw_top_chk rfcw_top_chk_i (.clk_i, .rst_i, .ce_i, .reg_addr_i,
	.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .wait_lower_byte_i,
	.rx_crc_err_clear_i, .rx_crc_error_o, .rx_check_done_o, .tx_req_i,
	.tx_go_o, .tx_end_i, .rx_end_i, .wait_active_o, .tx_payload_enable_o,
	.tx_final_byte_bits_o, .symbol_one_burst_size_o, .tx_stop_bit_o,
	.tx_guard_units_o);

// *** verif/rfcw_tag_model.sv ***
// Behavioural stand-in for the tags across the field.
// Assumes the bench calls its tasks at a falling clock edge.
`timescale 1ns/100ps
module rfcw_tag_model (
	// Clock
	input wire logic clk_i,
	// Receive stream into the block
	output logic [7:0] rx_data_o,
	output logic rx_valid_o,
	output logic rx_last_o,
	input wire logic rx_ready_i,
	// Frame ends
	output logic tx_end_o,
	output logic rx_end_o
);
	initial
	begin
		rx_data_o = 8'h5A;
		rx_valid_o = 1'b0;
		rx_last_o = 1'b0;
		tx_end_o = 1'b0;
		rx_end_o = 1'b0;
	end
	// A byte is held until taken or for 200 cycles; the idle line shows the inverted last byte.
	task automatic reply(input logic [7:0] q[$], output bit to);
		bit rdy;
		int k;
		to = 1'b0;
		foreach (q[i])
		begin
			rx_data_o = q[i];
			rx_valid_o = 1'b1;
			rx_last_o = (i == q.size() - 1);
			k = 0;
			do
			begin
				#1;
				rdy = rx_ready_i;
				@(negedge clk_i);
				k++;
			end
			while (!rdy && k < 200);
			to = to | !rdy;
		end
		rx_valid_o = 1'b0;
		rx_last_o = 1'b0;
		rx_data_o = ~rx_data_o;
	endtask
	task automatic pulse(input bit rx);
		if (rx)
			rx_end_o = 1'b1;
		else
			tx_end_o = 1'b1;
		@(negedge clk_i);
		rx_end_o = 1'b0;
		tx_end_o = 1'b0;
	endtask
endmodule

// *** verif/test_rfcw_top.sv ***
// Self-checking bench for the frame configuration block.
// Assumes the tag model drives the receive side and the frame ends.
`timescale 1ns/100ps
module test_rfcw_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_rdata_o;
	logic [15:0] user_crc_preset_i = 16'h5A3C;
	logic [7:0] wait_lower_byte_i = 8'h00;
	logic [11:0] half_bit_cycles_i = 12'h005;
	logic [7:0] rx_data_i;
	logic rx_valid_i, rx_last_i, rx_ready_o, rx_crc_error_o, rx_check_done_o;
	logic rx_crc_err_clear_i = 1'b0;
	logic fifo_ready_i = 1'b0;
	logic tx_req_i = 1'b0;
	logic [7:0] fifo_data_o;
	logic fifo_valid_o, tx_go_o, tx_end_i, rx_end_i, wait_active_o;
	logic tx_payload_enable_o, tx_stop_bit_o;
	logic [3:0] tx_final_byte_bits_o;
	logic [8:0] symbol_one_burst_size_o;
	logic [2:0] tx_guard_units_o;
	logic [15:0] pre [3][8] = '{
		'{16'h0000, 16'h0012, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h001F},
		'{16'h0000, 16'h0012, 16'h00BF, 16'h00FD, 16'h0, 16'h0, 16'h0, 16'h00FF},
		'{16'h0000, 16'h6363, 16'hA671, 16'hFFFE, 16'h0, 16'h0, 16'h0, 16'hFFFF}};
	logic [8:0] bl [8] = '{9'h008, 9'h010, 9'h020, 9'h030, 9'h040, 9'h060,
		9'h080, 9'h100};
	logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
	int miscompares = 0;
	int n_compared = 0;
	rfcw_top rfcw_top_i (.*);
	rfcw_tag_model rfcw_tag_model_i (.clk_i, .rx_data_o(rx_data_i),
		.rx_valid_o(rx_valid_i), .rx_last_o(rx_last_i),
		.rx_ready_i(rx_ready_o), .tx_end_o(tx_end_i), .rx_end_o(rx_end_i));
	initial
		forever #25 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		if (miscompares == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge clk_i);
		reg_wr_i = 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge clk_i);
		reg_rd_i = 1'b0;
		chk(reg_rdata_o, exp);
	endtask
	function automatic logic [15:0] crc_of(input logic [1:0] t,
		input logic [15:0] s, input logic [7:0] q[$]);
		logic [15:0] p;
		p = t == 2'h2 ? rfcw_pkg::POLY16 : t == 2'h1 ? rfcw_pkg::POLY8 :
			rfcw_pkg::POLY5;
		foreach (q[i])
			for (int b = 0; b < 8; b++)
				s = (s >> 1) ^ ((s[0] ^ q[i][b]) ? p : 16'h0000);
		return s;
	endfunction
	// Bytes are checked as they leave, then the buffer must be empty.
	task automatic drain(input logic [7:0] e[$], input int hold);
		int i;
		i = 0;
		repeat (hold) @(negedge clk_i);
		if (hold > 0)
			chk(rx_ready_o, 1'b0);
		fifo_ready_i = 1'b1;
		for (int k = 0; i < e.size() && k < 400; k++)
		begin
			if (fifo_valid_o === 1'b1)
			begin
				chk(fifo_data_o, e[i]);
				i++;
			end
			@(negedge clk_i);
		end
		chk(i, e.size());
		chk(fifo_valid_o, 1'b0);
		fifo_ready_i = 1'b0;
	endtask
	task automatic done_wait(input logic exp);
		int k;
		k = 0;
		do @(negedge clk_i);
		while (rx_check_done_o !== 1'b1 && ++k < 300);
		chk(rx_check_done_o, 1'b1);
		chk(rx_crc_error_o, exp);
		rx_crc_err_clear_i = 1'b1;
		@(negedge clk_i);
		rx_crc_err_clear_i = 1'b0;
	endtask
	// Flags are {forward, invert, check enable}.
	task automatic frame(input logic [1:0] t, input logic [2:0] pc,
		input logic [2:0] f, input int n, input bit bad, input int hold);
		logic [7:0] q[$];
		logic [7:0] e[$];
		logic [15:0] c, m;
		bit to;
		m = t == 2'h2 ? rfcw_pkg::MASK16 : t == 2'h1 ? rfcw_pkg::MASK8 :
			rfcw_pkg::MASK5;
		for (int i = 0; i < n; i++)
			q.push_back(8'h3C + 8'(i * 7));
		c = (pc == 3'h6 ? user_crc_preset_i : pre[t][pc]) & m;
		c = crc_of(t, c, q) ^ (f[1] ? m : 16'h0000) ^ {15'h0, bad};
		e = q;
		if (t != 2'h3)
			q.push_back(c[7:0]);
		if (t == 2'h2)
			q.push_back(c[15:8]);
		if (f[2])
			e = q;
		wr(rfcw_pkg::OFS_RX_CRC, {f[2], pc, t, f[1:0]});
		fork
			rfcw_tag_model_i.reply(q, to);
			drain(e, hold);
			if (t != 2'h3)
				done_wait(bad && f[0]);
		join
		chk(to, 1'b0);
	endtask
	task automatic go_after(input int k, input int exp);
		while (tx_go_o !== 1'b1 && k < 60000)
		begin
			@(negedge clk_i);
			k++;
		end
		if (exp >= 0)
			chk(k, exp);
		@(negedge clk_i);
		tx_req_i = 1'b0;
	endtask
	task automatic wait_case(input logic [7:0] w, input logic [7:0] lo,
		input int exp);
		wr(rfcw_pkg::OFS_TX_WAIT, w);
		wait_lower_byte_i = lo;
		tx_req_i = 1'b1;
		rfcw_tag_model_i.pulse(w[7]);
		go_after(1, exp);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(negedge clk_i);
		rst_i = 1'b0;
		rdc(8'h31, 8'hC0);
		rdc(8'h2D, 8'h00);
		rdc(8'h2E, 8'h00);
		rdc(8'h30, 8'h00);
		wr(8'h2F, 8'hFF);
		rdc(8'h2F, 8'h00);
		ce_i = 1'b0;
		wr(8'h2D, 8'hFF);
		ce_i = 1'b1;
		rdc(8'h2D, 8'h00);
		wr(8'h30, 8'hFF);
		rdc(8'h30, 8'h70);
		wr(8'h2E, 8'hFF);
		rdc(8'h2E, 8'h1F);
		for (int i = 0; i < 8; i++)
		begin
			wr(8'h2E, {4'h0, i[0], i[2:0]});
			wr(8'h30, {1'b0, i[2:0], 4'h0});
			wr(8'h31, {5'h18, i[2:0]});
			rdc(8'h31, {5'h18, i[2:0]});
			chk(symbol_one_burst_size_o, bl[i]);
			chk(tx_final_byte_bits_o, i == 0 ? 4'h8 : 4'(i));
			chk(tx_payload_enable_o, i[0]);
			chk({tx_stop_bit_o, tx_guard_units_o}, i == 0 ? 4'h0 :
				{1'b1, i > 1 ? 3'(i - 1) : 3'h0});
		end
		foreach (codes[j])
			for (int t = 0; t < 3; t++)
				if (t != 0 || codes[j] < 3'h2 || codes[j] > 3'h5)
					frame(2'(t), codes[j], {codes[j][1:0], 1'b1}, 3,
						codes[j][2], 0);
		frame(2'h2, 3'h7, 3'h0, 2, 1'b1, 0);
		frame(2'h3, 3'h0, 3'h0, 34, 1'b0, 60);
		wait_case(8'h80, 8'h01, rfcw_pkg::WAIT_UNIT_CYCLES + 1);
		wait_case(8'h08, 8'h00, 256 * rfcw_pkg::WAIT_UNIT_CYCLES + 1);
		wait_case(8'hC0, 8'h03, 3 * 5 + 1);
		wait_case(8'h38, 8'hFF, 2047 * rfcw_pkg::WAIT_UNIT_CYCLES + 1);
		wr(8'h2E, 8'h18);
		tx_req_i = 1'b1;
		go_after(0, -1);
		@(negedge clk_i);
		tx_req_i = 1'b1;
		go_after(2, 10);
		summarize();
	end
	initial
	begin
		#(90000 * 50);
		miscompares++;
		summarize();
	end
endmodule
